// ### hw/host_port_pkg.sv
// Package: shared constants and types for the framer host bus port.
// Assumes one 10 MHz clock and synchronous host pins.
package host_port_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int NUM_REGS = 16;
  localparam int STACK_DEPTH = 4;
  localparam int STACK_IDX_W = 2;
  localparam logic [ADDR_W-1:0] ADDR_RO_FIRST = 4'hE;
  localparam logic [ADDR_W-1:0] ADDR_RO_LAST = 4'hF;
  // Control register and its bits
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
  localparam int CTRL_STACK_EN_BIT = 0;
  localparam int CTRL_CLK_RATE_BIT = 1;
  localparam int CTRL_FRAME_MODE_BIT = 2;
  // Status registers (read only)
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'hE;
  localparam logic [ADDR_W-1:0] ADDR_RX_DATA = 4'hF;
  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
  // Host access timing
  localparam int HOST_SETUP_CYCLES = 1;
  localparam int HOST_STROBE_CYCLES = 2;
  localparam logic [1:0] HOST_CNT_W2 = 2'h2;
  // Clock rates in kHz
  localparam int SCLK_LOW_KHZ = 4096;
  localparam int SCLK_HIGH_KHZ = 8192;
  localparam int LINE_RATE_2048_KHZ = 2048;
  localparam int LINE_RATE_1544_KHZ = 1544;
  typedef logic [DATA_W-1:0] byte_t;
  typedef enum logic [3:0] {
    HS_IDLE = 4'b0001,
    HS_SETUP = 4'b0010,
    HS_STROBE = 4'b0100,
    HS_DONE = 4'b1000
  } host_state_e;
endpackage

// ### hw/host_port_if.sv
// Interface: the host-side pins of the framer port.
// Assumes both ends share clk; data bus resolved from enables.
`timescale 1ns/100ps
interface host_port_if;
  import host_port_pkg::*;
  logic [ADDR_W-1:0] addr;
  logic chip_select_n;
  logic read_strobe_n;
  logic write_strobe_n;
  logic stack_strobe_n;
  byte_t host_data_out;
  logic host_data_oe_n;
  byte_t dev_data_out;
  logic dev_data_oe_n;
  byte_t data_bus;
  always_comb begin
    if (!dev_data_oe_n) begin
      data_bus = dev_data_out;
    end else if (!host_data_oe_n) begin
      data_bus = host_data_out;
    end else begin
      data_bus = 8'hFF;
    end
  end
  modport device (
    input addr, chip_select_n, read_strobe_n, write_strobe_n, stack_strobe_n, data_bus,
    output dev_data_out, dev_data_oe_n
  );
  modport host (
    output addr, chip_select_n, read_strobe_n, write_strobe_n, stack_strobe_n,
    output host_data_out, host_data_oe_n,
    input data_bus
  );
endinterface

// ### hw/framer_host_bus_port.sv
// Device end: register file, signaling stacks, alarm override, line sampling.
// Assumes host pins synchronous to clk; line clock sampled as a plain input.
//
// Functional notes
// - Four address lines select one of sixteen registers
// - Host never writes addresses 0E or 0F
// - Select plus read strobe returns addressed register
// - Stack strobe plus read pops receive stack
// - Select plus write strobe stores host data
// - Stack strobe plus write pushes transmit stack
// - Carrier out of service forces unframed all-ones
// - Clock rate bit chooses 4096 or 8192 kHz
// - Line clock rate follows selected frame mode
// - Data lines driven only during reads
// - Receive data sampled on falling line clock
`timescale 1ns/100ps
module framer_host_bus_port (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Host pins
  host_port_if.device bus,
  // Framer side
  input wire logic carrier_out_of_service,
  input wire logic receive_line_clock,
  input wire logic rx_data_plus,
  input wire logic rx_data_minus,
  input wire logic tx_line_plus,
  input wire logic tx_line_minus,
  input wire logic tx_optical,
  input wire logic rx_sig_push,
  input wire host_port_pkg::byte_t rx_sig_data,
  input wire logic tx_sig_pop,
  output host_port_pkg::byte_t tx_sig_data,
  output logic tx_sig_valid,
  output logic line_out_plus,
  output logic line_out_minus,
  output logic optical_out,
  output logic stack_access_enable,
  output logic clock_rate_select,
  output logic frame_mode_2048,
  output host_port_pkg::byte_t ctrl_regs [host_port_pkg::NUM_REGS]
);
  import host_port_pkg::*;

  // ==========================================================
  // Access decode
  logic rd_reg, wr_reg, rd_stk, wr_stk, rd_prev, wr_prev;
  logic rd_start, wr_start;
  assign rd_reg = !bus.chip_select_n && !bus.read_strobe_n;
  assign wr_reg = !bus.chip_select_n && !bus.write_strobe_n;
  assign rd_stk = stack_access_enable && !bus.stack_strobe_n && !bus.read_strobe_n;
  assign wr_stk = stack_access_enable && !bus.stack_strobe_n && !bus.write_strobe_n;
  assign rd_start = (rd_reg || rd_stk) && !rd_prev;
  assign wr_start = (wr_reg || wr_stk) && !wr_prev;

  // ==========================================================
  // Register file and stacks
  byte_t regs [NUM_REGS];
  byte_t next_regs [NUM_REGS];
  byte_t rx_stack [STACK_DEPTH];
  byte_t next_rx_stack [STACK_DEPTH];
  byte_t tx_stack [STACK_DEPTH];
  byte_t next_tx_stack [STACK_DEPTH];
  logic [STACK_IDX_W:0] rx_cnt, next_rx_cnt, tx_cnt, next_tx_cnt;
  logic [STACK_IDX_W-1:0] rx_rd, next_rx_rd, rx_wr, next_rx_wr;
  logic [STACK_IDX_W-1:0] tx_rd, next_tx_rd, tx_wr, next_tx_wr;
  byte_t rd_data, next_rd_data;
  logic [1:0] rx_line, next_rx_line;
  logic line_clk_d, next_line_clk_d;
  logic rx_pop, tx_push, rx_do_push, tx_do_pop;
  logic next_rd_prev, next_wr_prev;

  assign rx_pop = rd_start && rd_stk && !rd_reg && (rx_cnt != '0);
  assign tx_push = wr_start && wr_stk && !wr_reg && (tx_cnt != 3'(STACK_DEPTH));
  assign rx_do_push = rx_sig_push && (rx_cnt != 3'(STACK_DEPTH) || rx_pop);
  assign tx_do_pop = tx_sig_pop && (tx_cnt != '0);

  always_comb begin
    next_regs = regs;
    next_rx_stack = rx_stack;
    next_tx_stack = tx_stack;
    next_rx_rd = rx_rd;
    next_rx_wr = rx_wr;
    next_tx_rd = tx_rd;
    next_tx_wr = tx_wr;
    next_rx_cnt = rx_cnt;
    next_tx_cnt = tx_cnt;
    next_rd_data = rd_data;
    next_rx_line = rx_line;
    next_line_clk_d = receive_line_clock;
    next_rd_prev = rd_reg || rd_stk;
    next_wr_prev = wr_reg || wr_stk;
    // Host writes to control registers; 0E and 0F are status only
    if (wr_start && wr_reg && bus.addr != ADDR_RO_FIRST && bus.addr != ADDR_RO_LAST) begin
      next_regs[bus.addr] = bus.data_bus;
    end
    if (tx_push) begin
      next_tx_stack[tx_wr] = bus.data_bus;
      next_tx_wr = tx_wr + 2'h1;
    end
    if (tx_do_pop) begin
      next_tx_rd = tx_rd + 2'h1;
    end
    next_tx_cnt = tx_cnt + 3'(tx_push) - 3'(tx_do_pop);
    if (rx_do_push) begin
      next_rx_stack[rx_wr] = rx_sig_data;
      next_rx_wr = rx_wr + 2'h1;
    end
    if (rx_pop) begin
      next_rx_rd = rx_rd + 2'h1;
    end
    next_rx_cnt = rx_cnt + 3'(rx_do_push) - 3'(rx_pop);
    // Read data captured at the start of the strobe
    if (rd_start) begin
      if (rd_reg) begin
        case (bus.addr)
          ADDR_STATUS: next_rd_data = {1'b0, rx_cnt, 1'b0, tx_cnt};
          ADDR_RX_DATA: next_rd_data = {6'h00, rx_line};
          default: next_rd_data = regs[bus.addr];
        endcase
      end else if (rx_cnt != '0) begin
        next_rd_data = rx_stack[rx_rd];
      end else begin
        next_rd_data = 8'h00;
      end
    end
    // Dual-rail input taken on falling line clock
    if (line_clk_d && !receive_line_clock) begin
      next_rx_line = {rx_data_plus, rx_data_minus};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs[i] <= REG_RESET;
      end
      for (int i = 0; i < STACK_DEPTH; i++) begin
        rx_stack[i] <= 8'h00;
        tx_stack[i] <= 8'h00;
      end
      rx_rd <= '0;
      rx_wr <= '0;
      tx_rd <= '0;
      tx_wr <= '0;
      rx_cnt <= '0;
      tx_cnt <= '0;
      rd_data <= 8'h00;
      rx_line <= 2'h0;
      line_clk_d <= 1'b0;
      rd_prev <= 1'b0;
      wr_prev <= 1'b0;
    end else begin
      regs <= next_regs;
      rx_stack <= next_rx_stack;
      tx_stack <= next_tx_stack;
      rx_rd <= next_rx_rd;
      rx_wr <= next_rx_wr;
      tx_rd <= next_tx_rd;
      tx_wr <= next_tx_wr;
      rx_cnt <= next_rx_cnt;
      tx_cnt <= next_tx_cnt;
      rd_data <= next_rd_data;
      rx_line <= next_rx_line;
      line_clk_d <= next_line_clk_d;
      rd_prev <= next_rd_prev;
      wr_prev <= next_wr_prev;
    end
  end

  // ==========================================================
  // Outputs
  assign bus.dev_data_out = rd_data;
  assign bus.dev_data_oe_n = !(rd_prev && (rd_reg || rd_stk));
  assign stack_access_enable = regs[ADDR_CTRL][CTRL_STACK_EN_BIT];
  assign clock_rate_select = regs[ADDR_CTRL][CTRL_CLK_RATE_BIT];
  assign frame_mode_2048 = regs[ADDR_CTRL][CTRL_FRAME_MODE_BIT];
  assign ctrl_regs = regs;
  assign tx_sig_data = tx_stack[tx_rd];
  assign tx_sig_valid = (tx_cnt != '0);

  // Alarm override: all ones, no framing
  logic next_line_out_plus, next_line_out_minus, next_optical_out;

  always_comb begin
    if (carrier_out_of_service) begin
      next_line_out_plus = ~line_out_plus;
      next_line_out_minus = line_out_plus;
      next_optical_out = 1'b1;
    end else begin
      next_line_out_plus = tx_line_plus;
      next_line_out_minus = tx_line_minus;
      next_optical_out = tx_optical;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      line_out_plus <= 1'b0;
      line_out_minus <= 1'b0;
      optical_out <= 1'b0;
    end else begin
      line_out_plus <= next_line_out_plus;
      line_out_minus <= next_line_out_minus;
      optical_out <= next_optical_out;
    end
  end
endmodule // framer_host_bus_port

// ### hw/framer_host_master.sv
// Host end: runs one read or write cycle per accepted request on the port pins; register writes to 0E or 0F are refused.
// Assumes the device end of the same interface on the same clock.
`timescale 1ns/100ps
module framer_host_master (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // User request
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_stack,
  input wire logic [host_port_pkg::ADDR_W-1:0] req_addr,
  input wire host_port_pkg::byte_t req_wdata,
  output logic req_ready,
  output logic resp_valid,
  output host_port_pkg::byte_t resp_rdata,
  output logic req_refused,
  // Port pins
  host_port_if.host bus
);
  import host_port_pkg::*;

  // ==========================================================
  // Cycle sequencer
  host_state_e state, next_state;
  logic [1:0] cnt, next_cnt;
  logic wr, next_wr, stk, next_stk;
  logic [ADDR_W-1:0] addr, next_addr;
  byte_t wdata, next_wdata, rdata, next_rdata;
  logic next_resp, next_refused;
  logic bad_wr;
  assign bad_wr = req_write && !req_stack
    && (req_addr == ADDR_RO_FIRST || req_addr == ADDR_RO_LAST);

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_wr = wr;
    next_stk = stk;
    next_addr = addr;
    next_wdata = wdata;
    next_rdata = rdata;
    next_resp = 1'b0;
    next_refused = 1'b0;
    case (state)
      HS_IDLE: begin
        if (req_valid && bad_wr) begin
          next_refused = 1'b1;
        end else if (req_valid) begin
          next_state = HS_SETUP;
          next_wr = req_write;
          next_stk = req_stack;
          next_addr = req_addr;
          next_wdata = req_wdata;
        end
      end
      HS_SETUP: begin
        next_state = HS_STROBE;
        next_cnt = 2'h0;
      end
      HS_STROBE: begin
        next_cnt = cnt + 2'h1;
        if (cnt == HOST_CNT_W2 - 2'h1) begin
          next_state = HS_DONE;
          next_rdata = bus.data_bus;
          next_resp = 1'b1;
        end
      end
      HS_DONE: next_state = HS_IDLE;
      default: next_state = HS_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= HS_IDLE;
      cnt <= 2'h0;
      wr <= 1'b0;
      stk <= 1'b0;
      addr <= '0;
      wdata <= 8'h00;
      rdata <= 8'h00;
      resp_valid <= 1'b0;
      req_refused <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      wr <= next_wr;
      stk <= next_stk;
      addr <= next_addr;
      wdata <= next_wdata;
      rdata <= next_rdata;
      resp_valid <= next_resp;
      req_refused <= next_refused;
    end
  end

  // ==========================================================
  // Pin drive
  logic strobe;
  assign strobe = (state == HS_STROBE);
  assign req_ready = (state == HS_IDLE);
  assign resp_rdata = rdata;
  assign bus.addr = addr;
  assign bus.chip_select_n = !((state != HS_IDLE) && !stk);
  assign bus.stack_strobe_n = !((state != HS_IDLE) && stk);
  assign bus.read_strobe_n = !(strobe && !wr);
  assign bus.write_strobe_n = !(strobe && wr);
  assign bus.host_data_out = wdata;
  assign bus.host_data_oe_n = !((state != HS_IDLE) && wr);
endmodule // framer_host_master

// ### sim/host_port_monitor.sv
// Monitor: concurrent checks on the host port pins between both ends.
// Assumes one clock domain and the signals of host_port_if as plain inputs.
`timescale 1ns/100ps
module host_port_monitor (
  // Clock and reset
  input logic clk,
  input logic rst_n,
  // Port pins
  input logic [host_port_pkg::ADDR_W-1:0] addr,
  input logic chip_select_n,
  input logic read_strobe_n,
  input logic write_strobe_n,
  input logic stack_strobe_n,
  input logic host_data_oe_n,
  input host_port_pkg::byte_t dev_data_out,
  input logic dev_data_oe_n,
  input host_port_pkg::byte_t data_bus
);
  import host_port_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // Assertions
  AST_OE_ON_READ: assert property (!dev_data_oe_n |-> !read_strobe_n)
    else $error("device drives data outside a read");
  AST_OE_SELECTED: assert property (!dev_data_oe_n |->
    !chip_select_n || !stack_strobe_n)
    else $error("device drives data while not selected");
  AST_READ_ANSWER: assert property ($fell(read_strobe_n) && !chip_select_n |->
    ##[1:2] !dev_data_oe_n)
    else $error("register read not answered");
  AST_OE_RELEASE: assert property (read_strobe_n && $past(read_strobe_n) |->
    dev_data_oe_n)
    else $error("data lines not released after read");
  AST_READ_STABLE: assert property (!dev_data_oe_n && !$past(dev_data_oe_n) |->
    $stable(dev_data_out))
    else $error("read data changed during strobe");
  AST_NO_RO_WRITE: assert property (!chip_select_n && !write_strobe_n |->
    addr < ADDR_RO_FIRST)
    else $error("write cycle to read-only address");
  AST_WRITE_DRIVES: assert property (!write_strobe_n |->
    !host_data_oe_n && dev_data_oe_n)
    else $error("wrong data driver during write");
  AST_WRITE_LEN: assert property ($fell(write_strobe_n) |->
    !write_strobe_n [*2] ##1 write_strobe_n)
    else $error("write strobe length wrong");
  AST_WRITE_HOLD: assert property (!write_strobe_n && !$past(write_strobe_n) |->
    $stable(data_bus) && $stable(addr))
    else $error("write data or address moved");
  // ==========================================================
  // Covers
  cover property (!stack_strobe_n && !dev_data_oe_n);
  cover property (!stack_strobe_n && !write_strobe_n);
  cover property (!chip_select_n && !write_strobe_n);
endmodule // host_port_monitor

// ### sim/test_framer_host_bus_port.sv
// Bench: host end and device end joined, compared with a queue model.
// Assumes the package, the interface and both ends compiled first.
`timescale 1ns/100ps
module test_framer_host_bus_port;
  import host_port_pkg::*;
  logic clk, rst_n, req_valid, req_write, req_stack, req_ready, resp_valid, req_refused;
  logic cos, rlc, rdp, rdm, tlp, tlm, tlo, rx_sig_push, tx_sig_pop, tx_sig_valid;
  logic lop, lom, oo, sae, crs, fm;
  logic [ADDR_W-1:0] req_addr;
  logic [1:0] line_s;
  byte_t req_wdata, resp_rdata, rx_sig_data, tx_sig_data, v;
  byte_t ctrl_regs [NUM_REGS];
  byte_t regs [16];
  byte_t txq [$];
  byte_t rxq [$];
  int err_total, num_checks;
  int unsigned st = 47;
  host_port_if bus();
  framer_host_master u_framer_host_master(.clk(clk), .rst_n(rst_n), .req_valid(req_valid),
    .req_write(req_write), .req_stack(req_stack), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_ready(req_ready), .resp_valid(resp_valid), .resp_rdata(resp_rdata),
    .req_refused(req_refused), .bus(bus));
  framer_host_bus_port u_framer_host_bus_port(.clk(clk), .rst_n(rst_n), .bus(bus),
    .carrier_out_of_service(cos), .receive_line_clock(rlc), .rx_data_plus(rdp),
    .rx_data_minus(rdm), .tx_line_plus(tlp), .tx_line_minus(tlm), .tx_optical(tlo),
    .rx_sig_push(rx_sig_push), .rx_sig_data(rx_sig_data), .tx_sig_pop(tx_sig_pop),
    .tx_sig_data(tx_sig_data), .tx_sig_valid(tx_sig_valid), .line_out_plus(lop),
    .line_out_minus(lom), .optical_out(oo), .stack_access_enable(sae),
    .clock_rate_select(crs), .frame_mode_2048(fm), .ctrl_regs(ctrl_regs));
  host_port_monitor u_mon(.clk(clk), .rst_n(rst_n), .addr(bus.addr),
    .chip_select_n(bus.chip_select_n), .read_strobe_n(bus.read_strobe_n),
    .write_strobe_n(bus.write_strobe_n), .stack_strobe_n(bus.stack_strobe_n),
    .host_data_oe_n(bus.host_data_oe_n), .dev_data_out(bus.dev_data_out),
    .dev_data_oe_n(bus.dev_data_oe_n), .data_bus(bus.data_bus));
  // ==========================================================
  // Helpers
  function automatic byte_t rnd();
    st ^= st << 13;
    st ^= st >> 17;
    st ^= st << 5;
    return st[7:0];
  endfunction
  task automatic check(input byte_t seen, input byte_t exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks=%0d errors=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic xfer(input logic w, input logic s, input logic [3:0] a, input byte_t d);
    int n;
    byte_t e;
    logic bad;
    bad = w && !s && a >= ADDR_RO_FIRST;
    e = 8'h00;
    if (w && !s && !bad) regs[a] = d;
    if (w && s && regs[0][0] && txq.size() < STACK_DEPTH) txq.push_back(d);
    if (!w && s && rxq.size() > 0) e = rxq.pop_front();
    if (!w && !s) e = regs[a];
    if (!w && !s && a == ADDR_STATUS) e = {1'b0, 3'(rxq.size()), 1'b0, 3'(txq.size())};
    if (!w && !s && a == ADDR_RX_DATA) e = {6'h00, line_s};
    @(posedge clk);
    req_valid <= 1'b1;
    req_write <= w;
    req_stack <= s;
    req_addr <= a;
    req_wdata <= d;
    @(posedge clk);
    req_valid <= 1'b0;
    for (n = 0; n < 20; n++) begin
      #1;
      if (resp_valid === 1'b1 || req_refused === 1'b1) break;
      @(posedge clk);
    end
    check(8'(n < 20), 8'h01);
    check({7'h00, req_refused}, {7'h00, bad});
    check({7'h00, req_ready}, {7'h00, bad});
    if (!w) check(resp_rdata, e);
  endtask
  // ==========================================================
  // Clock, watchdog, sequence
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    #2000000;
    err_total++;
    end_sim();
  end
  initial begin
    {rst_n, req_valid, req_write, req_stack, cos, rlc, rdp, rdm, tlp, tlm, tlo} = '0;
    {rx_sig_push, tx_sig_pop, req_addr, req_wdata, rx_sig_data, line_s} = '0;
    {err_total, num_checks} = '0;
    foreach (regs[i]) regs[i] = 8'h00;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    for (int a = 1; a < 16; a++) xfer(1'b1, 1'b0, 4'(a), rnd());
    for (int a = 0; a < 16; a++) xfer(1'b0, 1'b0, 4'(a), 8'h00);
    for (int a = 0; a < 14; a++) check(ctrl_regs[a], regs[a]);
    for (int m = 0; m < 8; m++) begin
      xfer(1'b1, 1'b0, 4'h0, 8'(m));
      check({5'h00, fm, crs, sae}, 8'(m));
    end
    xfer(1'b1, 1'b0, 4'h0, 8'h01);
    repeat (5) xfer(1'b1, 1'b1, 4'h0, rnd());
    xfer(1'b0, 1'b0, ADDR_STATUS, 8'h00);
    while (txq.size() > 0) begin
      check({7'h00, tx_sig_valid}, 8'h01);
      check(tx_sig_data, txq.pop_front());
      @(posedge clk);
      tx_sig_pop <= 1'b1;
      @(posedge clk);
      tx_sig_pop <= 1'b0;
      #1;
    end
    check({7'h00, tx_sig_valid}, 8'h00);
    repeat (5) begin
      @(posedge clk);
      v = rnd();
      rx_sig_push <= 1'b1;
      rx_sig_data <= v;
      if (rxq.size() < STACK_DEPTH) rxq.push_back(v);
    end
    @(posedge clk);
    rx_sig_push <= 1'b0;
    xfer(1'b0, 1'b0, ADDR_STATUS, 8'h00);
    repeat (5) xfer(1'b0, 1'b1, 4'h0, 8'h00);
    @(posedge clk);
    cos <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    v[0] = lop;
    repeat (4) begin
      @(posedge clk);
      #1;
      check({5'h00, oo, lom, lop}, {5'h00, 1'b1, v[0], ~v[0]});
      v[0] = lop;
    end
    @(posedge clk);
    cos <= 1'b0;
    repeat (3) @(posedge clk);
    repeat (8) begin
      @(posedge clk);
      v = rnd();
      {tlp, tlm, tlo} <= v[2:0];
      @(posedge clk);
      #1;
      check({5'h00, lop, lom, oo}, {5'h00, v[2:0]});
    end
    @(posedge clk);
    {rlc, rdp, rdm} <= 3'b110;
    repeat (3) @(posedge clk);
    rlc <= 1'b0;
    repeat (3) @(posedge clk);
    {rdp, rdm} <= 2'b01;
    repeat (3) @(posedge clk);
    rlc <= 1'b1;
    line_s = 2'b10;
    xfer(1'b0, 1'b0, ADDR_RX_DATA, 8'h00);
    end_sim();
  end
endmodule // test_framer_host_bus_port
